// ### cpu_bit_control_alu_decode_consts.vh
`ifndef CPU_BIT_CONTROL_ALU_DECODE_CONSTS_VH
`define CPU_BIT_CONTROL_ALU_DECODE_CONSTS_VH

// Condition code bit positions
`define CCR_H 4
`define CCR_I 3
`define CCR_N 2
`define CCR_Z 1
`define CCR_C 0

// Reset values and the page-zero high byte
`define CCR_RESET 5'h08
`define SP_RESET 8'hFF
`define ACC_RESET 8'h00
`define IDX_RESET 8'h00
`define PAGE_ZERO 8'h00

// Vector addresses (high byte first)
`define VEC_RESET 16'hFFFE
`define VEC_SWI 16'hFFFC
`define VEC_IRQ 16'hFFFA

// Low opcode nibbles of the arithmetic, logic and shift groups
`define LO_ADC 4'h9
`define LO_ADD 4'hB
`define LO_AND 4'h4
`define LO_ASL 4'h8
`define LO_ASR 4'h7

// Inherent control opcodes
`define OP_RTI 8'h80
`define OP_RTS 8'h81
`define OP_SWI 8'h83
`define OP_STOP 8'h8E
`define OP_WAIT 8'h8F
`define OP_TAX 8'h97
`define OP_CLC 8'h98
`define OP_SEC 8'h99
`define OP_CLI 8'h9A
`define OP_SEI 8'h9B
`define OP_RSP 8'h9C
`define OP_TXA 8'h9F

// Cycle counts per instruction and for the interrupt entry
`define CYC_IMM 4'd2
`define CYC_DIR 4'd3
`define CYC_EXT 4'd4
`define CYC_IX2 4'd5
`define CYC_IX1 4'd4
`define CYC_IX 4'd3
`define CYC_RMW_DIR 4'd5
`define CYC_RMW_INH 4'd3
`define CYC_RMW_IX1 4'd6
`define CYC_RMW_IX 4'd5
`define CYC_BIT 4'd5
`define CYC_REL 4'd3
`define CYC_INH 4'd2
`define CYC_RTS 4'd6
`define CYC_RTI 4'd9
`define CYC_SWI 4'd10
`define CYC_IRQ 4'd10

`endif

// ### cpu_bit_control_alu_decode.v
`timescale 1ns/1ps
`include "cpu_bit_control_alu_decode_consts.vh"
module cpu_bit_control_alu_decode (
    // Clock, reset, enable
    input wire clk,
    input wire resetn,
    input wire ce,
    // Memory and peripheral bus
    output reg [15:0] mem_addr,
    output reg [7:0] mem_wdata,
    output reg mem_we,
    input wire [7:0] mem_rdata,
    // Interrupt pin and low power
    input wire irq_pin_n,
    output reg osc_stop,
    output reg cpu_wait,
    // Core state
    output reg [7:0] acc,
    output reg [7:0] index,
    output reg [15:0] pc,
    output reg [7:0] sp,
    output reg [4:0] ccr
);

localparam [11:0] S_DEC = 12'h001;
localparam [11:0] S_OPB = 12'h002;
localparam [11:0] S_MEM = 12'h004;
localparam [11:0] S_EXE = 12'h008;
localparam [11:0] S_WR = 12'h010;
localparam [11:0] S_PAD = 12'h020;
localparam [11:0] S_PSH = 12'h040;
localparam [11:0] S_PUL = 12'h080;
localparam [11:0] S_VEC0 = 12'h100;
localparam [11:0] S_VEC1 = 12'h200;
localparam [11:0] S_VEC2 = 12'h400;
localparam [11:0] S_HALT = 12'h800;

localparam [1:0] D_NONE = 2'd0;
localparam [1:0] D_ACC = 2'd1;
localparam [1:0] D_IDX = 2'd2;
localparam [1:0] D_MEM = 2'd3;

reg [11:0] state;
reg [7:0] op;
reg [1:0] nb;
reg [7:0] lo;
reg [7:0] hi;
reg [3:0] cyc;
reg [3:0] cnt;
reg [2:0] k;
reg [15:0] vaddr;

reg [7:0] val;
reg [7:0] res;
reg [7:0] mask;
reg [7:0] rel;
reg cin;
reg [8:0] sum;
reg [4:0] half;
reg [15:0] base;
reg [15:0] pc_new;
reg [15:0] ea_now;
reg [4:0] nccr;
reg [1:0] dst;
reg take;
reg cond;

function [1:0] nbytes;
    input [7:0] o;
    begin
        case (o[7:4])
            4'h0, 4'hC, 4'hD: nbytes = 2'd2;
            4'h1, 4'h2, 4'h3, 4'h6, 4'hA, 4'hB, 4'hE: nbytes = 2'd1;
            default: nbytes = 2'd0;
        endcase
    end
endfunction

function needmem;
    input [7:0] o;
    begin
        case (o[7:4])
            4'h0, 4'h1, 4'h3, 4'h6, 4'h7: needmem = 1'b1;
            4'hB, 4'hC, 4'hD, 4'hE, 4'hF: needmem = 1'b1;
            default: needmem = 1'b0;
        endcase
    end
endfunction

function [3:0] cycles;
    input [7:0] o;
    begin
        case (o[7:4])
            4'h0, 4'h1: cycles = `CYC_BIT;
            4'h2: cycles = `CYC_REL;
            4'h3: cycles = `CYC_RMW_DIR;
            4'h4, 4'h5: cycles = `CYC_RMW_INH;
            4'h6: cycles = `CYC_RMW_IX1;
            4'h7: cycles = `CYC_RMW_IX;
            4'hA: cycles = `CYC_IMM;
            4'hB: cycles = `CYC_DIR;
            4'hC: cycles = `CYC_EXT;
            4'hD: cycles = `CYC_IX2;
            4'hE: cycles = `CYC_IX1;
            4'hF: cycles = `CYC_IX;
            default: begin
                if (o == `OP_RTS)
                    cycles = `CYC_RTS;
                else if (o == `OP_RTI)
                    cycles = `CYC_RTI;
                else if (o == `OP_SWI)
                    cycles = `CYC_SWI;
                else
                    cycles = `CYC_INH;
            end
        endcase
    end
endfunction

function [2:0] bitsel;
    input [7:0] o;
    begin
        case (o[3:1])
            3'd7: bitsel = 3'd7;
            3'd0: bitsel = 3'd6;
            default: bitsel = o[3:1] - 3'd1;
        endcase
    end
endfunction

always @* begin
    val = (state == S_EXE) ? (op[4] ? index : acc) : mem_rdata;
    cin = (op[3:0] == `LO_ADC) ? ccr[`CCR_C] : 1'b0;
    sum = {1'b0, acc} + {1'b0, val} + {8'h00, cin};
    half = {1'b0, acc[3:0]} + {1'b0, val[3:0]} + {4'h0, cin};
    mask = 8'h01 << bitsel(op);
    base = (state == S_OPB) ? pc + 16'h0001 : pc;
    rel = (state == S_OPB) ? mem_rdata : lo;
    res = val;
    nccr = ccr;
    dst = D_NONE;
    take = 1'b0;
    cond = 1'b0;
    ea_now = {`PAGE_ZERO, mem_rdata};
    case (op[7:4])
        4'h0: ea_now = {`PAGE_ZERO, lo};
        4'h6, 4'hE: ea_now = {7'h00, {1'b0, index} + {1'b0, mem_rdata}};
        4'hC: ea_now = {lo, mem_rdata};
        4'hD: ea_now = {lo, mem_rdata} + {8'h00, index};
        default: ea_now = {`PAGE_ZERO, mem_rdata};
    endcase
    case (op[7:4])
        4'h0: begin
            cond = (mem_rdata & mask) != 8'h00;
            take = cond ^ op[0];
            nccr[`CCR_C] = cond;
        end
        4'h1: begin
            res = op[0] ? (val & ~mask) : (val | mask);
            dst = D_MEM;
        end
        4'h2: begin
            case (op[3:1])
                3'd0: cond = 1'b1;
                3'd1: cond = ~(ccr[`CCR_C] | ccr[`CCR_Z]);
                3'd2: cond = ~ccr[`CCR_C];
                3'd3: cond = ~ccr[`CCR_Z];
                3'd4: cond = ~ccr[`CCR_H];
                3'd5: cond = ~ccr[`CCR_N];
                3'd6: cond = ~ccr[`CCR_I];
                default: cond = ~irq_pin_n;
            endcase
            take = cond ^ op[0];
        end
        4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
            if (op[3:0] == `LO_ASL || op[3:0] == `LO_ASR) begin
                if (op[3:0] == `LO_ASL) begin
                    res = {val[6:0], 1'b0};
                    nccr[`CCR_C] = val[7];
                end else begin
                    res = {val[7], val[7:1]};
                    nccr[`CCR_C] = val[0];
                end
                nccr[`CCR_N] = res[7];
                nccr[`CCR_Z] = (res == 8'h00);
                if (op[7:4] == 4'h4)
                    dst = D_ACC;
                else if (op[7:4] == 4'h5)
                    dst = D_IDX;
                else
                    dst = D_MEM;
            end
        end
        4'h8, 4'h9: begin
            case (op)
                `OP_TAX: begin
                    res = acc;
                    dst = D_IDX;
                end
                `OP_TXA: begin
                    res = index;
                    dst = D_ACC;
                end
                `OP_CLC: nccr[`CCR_C] = 1'b0;
                `OP_SEC: nccr[`CCR_C] = 1'b1;
                `OP_CLI: nccr[`CCR_I] = 1'b0;
                `OP_SEI: nccr[`CCR_I] = 1'b1;
                default: nccr = ccr;
            endcase
        end
        default: begin
            if (op[3:0] == `LO_ADC || op[3:0] == `LO_ADD) begin
                res = sum[7:0];
                nccr[`CCR_H] = half[4];
                nccr[`CCR_C] = sum[8];
                nccr[`CCR_N] = res[7];
                nccr[`CCR_Z] = (res == 8'h00);
                dst = D_ACC;
            end else if (op[3:0] == `LO_AND) begin
                res = acc & val;
                nccr[`CCR_N] = res[7];
                nccr[`CCR_Z] = (res == 8'h00);
                dst = D_ACC;
            end
        end
    endcase
    pc_new = take ? base + {{8{rel[7]}}, rel} : base;
end

task finish;
    input [15:0] npc;
    begin
        if (cyc + 4'h1 >= cnt) begin
            state <= S_DEC;
            mem_addr <= npc;
        end else begin
            state <= S_PAD;
        end
    end
endtask

task commit;
    begin
        ccr <= nccr;
        pc <= pc_new;
        if (dst == D_ACC)
            acc <= res;
        if (dst == D_IDX)
            index <= res;
        if (dst == D_MEM) begin
            mem_we <= 1'b1;
            mem_wdata <= res;
            state <= S_WR;
        end else begin
            finish(pc_new);
        end
    end
endtask

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        state <= S_VEC0;
        mem_addr <= 16'h0000;
        mem_wdata <= 8'h00;
        mem_we <= 1'b0;
        osc_stop <= 1'b0;
        cpu_wait <= 1'b0;
        acc <= `ACC_RESET;
        index <= `IDX_RESET;
        pc <= 16'h0000;
        sp <= `SP_RESET;
        ccr <= `CCR_RESET;
        op <= 8'h00;
        nb <= 2'd0;
        lo <= 8'h00;
        hi <= 8'h00;
        cyc <= 4'h0;
        cnt <= 4'h0;
        k <= 3'd0;
        vaddr <= `VEC_RESET;
    end else if (ce) begin
        mem_we <= 1'b0;
        cyc <= cyc + 4'h1;
        case (state)
            S_DEC: begin
                cyc <= 4'h1;
                if (!irq_pin_n && !ccr[`CCR_I]) begin
                    cnt <= `CYC_IRQ;
                    vaddr <= `VEC_IRQ;
                    k <= 3'd0;
                    state <= S_PSH;
                end else begin
                    op <= mem_rdata;
                    cnt <= cycles(mem_rdata);
                    nb <= nbytes(mem_rdata);
                    pc <= pc + 16'h0001;
                    mem_addr <= pc + 16'h0001;
                    if (nbytes(mem_rdata) != 2'd0)
                        state <= S_OPB;
                    else if (needmem(mem_rdata)) begin
                        mem_addr <= {`PAGE_ZERO, index};
                        state <= S_MEM;
                    end else
                        state <= S_EXE;
                end
            end
            S_OPB: begin
                lo <= mem_rdata;
                hi <= lo;
                nb <= nb - 2'd1;
                pc <= pc + 16'h0001;
                mem_addr <= pc + 16'h0001;
                if (nb == 2'd1) begin
                    if (needmem(op)) begin
                        mem_addr <= ea_now;
                        state <= S_MEM;
                    end else
                        commit;
                end
            end
            S_MEM: commit;
            S_EXE: begin
                case (op)
                    `OP_RSP: begin
                        sp <= `SP_RESET;
                        commit;
                    end
                    `OP_STOP: begin
                        osc_stop <= 1'b1;
                        ccr[`CCR_I] <= 1'b0;
                        state <= S_HALT;
                    end
                    `OP_WAIT: begin
                        cpu_wait <= 1'b1;
                        ccr[`CCR_I] <= 1'b0;
                        state <= S_HALT;
                    end
                    `OP_SWI: begin
                        k <= 3'd0;
                        vaddr <= `VEC_SWI;
                        state <= S_PSH;
                    end
                    `OP_RTI, `OP_RTS: begin
                        k <= (op == `OP_RTI) ? 3'd0 : 3'd3;
                        mem_addr <= {`PAGE_ZERO, sp + 8'h01};
                        sp <= sp + 8'h01;
                        state <= S_PUL;
                    end
                    default: commit;
                endcase
            end
            S_WR, S_PAD: finish(pc);
            S_PSH: begin
                mem_addr <= {`PAGE_ZERO, sp};
                mem_we <= 1'b1;
                sp <= sp - 8'h01;
                k <= k + 3'd1;
                case (k)
                    3'd0: mem_wdata <= pc[7:0];
                    3'd1: mem_wdata <= pc[15:8];
                    3'd2: mem_wdata <= index;
                    3'd3: mem_wdata <= acc;
                    default: mem_wdata <= {3'b111, ccr};
                endcase
                if (k == 3'd4)
                    state <= S_VEC0;
            end
            S_PUL: begin
                case (k)
                    3'd0: ccr <= mem_rdata[4:0];
                    3'd1: acc <= mem_rdata;
                    3'd2: index <= mem_rdata;
                    3'd3: hi <= mem_rdata;
                    default: pc <= {hi, mem_rdata};
                endcase
                if (k == 3'd4)
                    finish({hi, mem_rdata});
                else begin
                    k <= k + 3'd1;
                    mem_addr <= {`PAGE_ZERO, sp + 8'h01};
                    sp <= sp + 8'h01;
                end
            end
            S_VEC0: begin
                mem_addr <= vaddr;
                ccr[`CCR_I] <= 1'b1;
                state <= S_VEC1;
            end
            S_VEC1: begin
                hi <= mem_rdata;
                mem_addr <= vaddr + 16'h0001;
                state <= S_VEC2;
            end
            S_VEC2: begin
                pc <= {hi, mem_rdata};
                finish({hi, mem_rdata});
            end
            S_HALT: begin
                if (!irq_pin_n) begin
                    osc_stop <= 1'b0;
                    cpu_wait <= 1'b0;
                    mem_addr <= pc;
                    state <= S_DEC;
                end
            end
            default: state <= S_DEC;
        endcase
    end
end

endmodule // cpu_bit_control_alu_decode

// ### cpu_bit_control_alu_decode_monitor.sv
`timescale 1ns/1ps
`include "cpu_bit_control_alu_decode_consts.vh"
module cpu_bit_control_alu_decode_monitor (
    // Clock and inputs
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire irq_pin_n,
    // Watched outputs
    input wire [15:0] mem_addr,
    input wire mem_we,
    input wire osc_stop,
    input wire cpu_wait,
    input wire [7:0] acc,
    input wire [15:0] pc,
    input wire [4:0] ccr
);
    default clocking mc @(posedge clk); endclocking
    default disable iff (!resetn);

    stop_holds_a: assert property (
        osc_stop && irq_pin_n && ce |=> osc_stop && $stable(pc) && $stable(acc))
        else $error("stop state left without interrupt");
    stop_mask_a: assert property (osc_stop |-> !ccr[`CCR_I])
        else $error("interrupt mask set while stopped");
    halt_alone_a: assert property (!(osc_stop && cpu_wait))
        else $error("stop and wait both high");
    wait_holds_a: assert property (
        cpu_wait && irq_pin_n && ce |=> cpu_wait && $stable(pc))
        else $error("wait state left without interrupt");
    wait_mask_a: assert property (cpu_wait |-> !ccr[`CCR_I])
        else $error("interrupt mask set while waiting");
    halt_wake_a: assert property (
        (cpu_wait || osc_stop) && !irq_pin_n && ce |-> ##[1:40] mem_addr == 16'hFFFA)
        else $error("no interrupt vector fetch after wake");
    low_write_a: assert property (mem_we |-> mem_addr[15:9] == 7'h00)
        else $error("write outside the low pages");
    swi_vector_a: assert property (
        mem_addr == 16'hFFFC && ce |=> mem_addr == 16'hFFFD)
        else $error("software vector not read high byte first");
    write_burst_a: assert property ((mem_we && ce) [*5] |=> !mem_we)
        else $error("write burst longer than five");
endmodule // cpu_bit_control_alu_decode_monitor

// ### mem_model.sv
`timescale 1ns/1ps
module mem_model (
    // Clock
    input wire clk,
    input wire ce,
    // Bus from the core
    input wire [15:0] mem_addr,
    input wire [7:0] mem_wdata,
    input wire mem_we,
    output wire [7:0] mem_rdata
);
    reg [7:0] mem [0:65535];
    integer k;
    initial begin
        for (k = 0; k < 65536; k = k + 1) begin
            mem[k] = 8'h9D;
        end
    end
    assign mem_rdata = mem[mem_addr];
    always @(posedge clk) begin
        if (mem_we && ce) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule // mem_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
    reg clk;
    reg resetn;
    reg ce;
    reg irq_pin_n;
    wire [15:0] mem_addr;
    wire [7:0] mem_wdata;
    wire mem_we;
    wire [7:0] mem_rdata;
    wire osc_stop;
    wire cpu_wait;
    wire [7:0] acc;
    wire [7:0] index;
    wire [15:0] pc;
    wire [7:0] sp;
    wire [4:0] ccr;
    int bad_count = 0;
    int tests_run = 0;
    logic [15:0] ipc;
    logic [7:0] a, x, s;
    logic h, i, n, z, c;

    cpu_bit_control_alu_decode u_cpu_bit_control_alu_decode (
        .clk(clk), .resetn(resetn), .ce(ce), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_rdata(mem_rdata), .irq_pin_n(irq_pin_n), .osc_stop(osc_stop),
        .cpu_wait(cpu_wait), .acc(acc), .index(index), .pc(pc), .sp(sp), .ccr(ccr));
    mem_model u_mem_model (
        .clk(clk), .ce(ce), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .mem_rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic stuck(input string what);
        bad_count++;
        $display("ERROR %s expected response seen none", what);
        test_done;
    endtask
    task automatic chk_addr(input string what, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic put(input logic [15:0] ad, input logic [7:0] v);
        u_mem_model.mem[ad] = v;
    endtask
    function automatic logic [15:0] rel(input logic [15:0] base, input logic [7:0] r);
        rel = base + {{8{r[7]}}, r};
    endfunction
    function automatic logic [2:0] bc(input int b);
        bc = (b < 6) ? 3'(b + 1) : (b == 6) ? 3'h0 : 3'h7;
    endfunction
    task automatic run(input int cyc, input logic [15:0] nxt);
        tick(cyc);
        chk_addr("next fetch", nxt, mem_addr);
        chk_addr("pc", nxt, pc);
        ipc = nxt;
    endtask
    task automatic regs;
        chk_byte("acc", a, acc);
        chk_byte("index", x, index);
        chk_byte("sp", s, sp);
        chk_byte("ccr", {3'h0, h, i, n, z, c}, {3'h0, ccr});
    endtask
    task automatic nz(input logic [7:0] r);
        n = r[7];
        z = (r == 8'h00);
    endtask

    task automatic alu(input logic [3:0] lo, input logic [3:0] m, input logic [7:0] v);
        int cyc [6] = '{2, 3, 4, 5, 4, 3};
        int len [6] = '{2, 2, 3, 3, 2, 1};
        logic [15:0] r, off, ea;
        int t, cin;
        r = 16'($urandom);
        off = (m == 4'h2) ? {4'h4, r[11:0]} : (m == 4'h3) ? {4'h5, r[11:0]} :
            (m == 4'h5) ? 16'h0000 : (m == 4'h0) ? {8'h00, v} : {10'h001, r[5:0]};
        ea = off + ((m >= 4'h3) ? {8'h00, x} : 16'h0000);
        put(ipc, {4'hA + m, lo});
        put(ipc + 16'h0001, (len[m] == 3) ? off[15:8] : off[7:0]);
        put(ipc + 16'h0002, off[7:0]);
        if (m != 4'h0) put(ea, v);
        cin = (lo == 4'h9) ? int'(c) : 0;
        if (lo == 4'h4) begin
            a = a & v;
        end else begin
            t = int'(a) + int'(v) + cin;
            h = (int'(a[3:0]) + int'(v[3:0]) + cin) > 15;
            c = t > 255;
            a = t[7:0];
        end
        nz(a);
        run(cyc[m], ipc + 16'(len[m]));
        regs();
    endtask

    task automatic sh(input logic [3:0] hi, input logic [3:0] lo, input logic [7:0] rv);
        int cyc [5] = '{5, 3, 3, 6, 5};
        logic [15:0] ea;
        logic [7:0] v, r;
        logic memf;
        ea = (hi == 4'h7) ? {8'h00, x} : {10'h001, rv[5:0]} + ((hi == 4'h6) ? x : 8'h00);
        memf = (hi != 4'h4) && (hi != 4'h5);
        v = (hi == 4'h4) ? a : (hi == 4'h5) ? x : rv;
        put(ipc, {hi, lo});
        put(ipc + 16'h0001, {2'b01, rv[5:0]});
        if (memf) put(ea, v);
        r = (lo == 4'h8) ? {v[6:0], 1'b0} : {v[7], v[7:1]};
        c = (lo == 4'h8) ? v[7] : v[0];
        nz(r);
        if (hi == 4'h4) a = r;
        if (hi == 4'h5) x = r;
        run(cyc[hi - 4'h3], ipc + ((hi == 4'h3 || hi == 4'h6) ? 16'h0002 : 16'h0001));
        regs();
        if (memf) chk_byte("shifted byte", r, u_mem_model.mem[ea]);
    endtask

    task automatic bits(input int b, input logic clr, input logic br, input logic [15:0] rv);
        logic [7:0] dd, v, e;
        dd = {2'b01, rv[5:0]};
        v = rv[15:8];
        put(ipc, {3'h0, ~br, bc(b), clr});
        put(ipc + 16'h0001, dd);
        put(ipc + 16'h0002, rv[13:6]);
        put({8'h00, dd}, v);
        if (br) begin
            c = v[b];
            run(5, (c ^ clr) ? rel(ipc + 16'h0003, rv[13:6]) : ipc + 16'h0003);
        end else begin
            e = clr ? v & ~(8'h01 << b) : v | (8'h01 << b);
            run(5, ipc + 16'h0002);
            chk_byte("bit target", e, u_mem_model.mem[{8'h00, dd}]);
        end
        regs();
    endtask

    task automatic br(input logic [7:0] op, input logic [7:0] rr);
        logic t;
        t = (op == 8'h24) ? !c : (op == 8'h25) ? c : (op == 8'h27) ? z : !h;
        put(ipc, op);
        put(ipc + 16'h0001, rr);
        run(3, t ? rel(ipc + 16'h0002, rr) : ipc + 16'h0002);
        regs();
    endtask

    task automatic ctl(input logic [7:0] op);
        case (op)
            8'h97: x = a;
            8'h9F: a = x;
            8'h98: c = 1'b0;
            8'h99: c = 1'b1;
            8'h9C: s = 8'hFF;
            default: ;
        endcase
        put(ipc, op);
        run(2, ipc + 16'h0001);
        regs();
    endtask

    task automatic trap(input logic [7:0] op);
        logic [15:0] ret, hv;
        logic [7:0] st [5];
        logic si;
        int k;
        ret = ipc + 16'h0001;
        hv = (op == 8'h83) ? 16'h0F00 : 16'h0E00;
        put(ipc, op);
        if (op == 8'h83) begin
            st = '{{3'h7, h, i, n, z, c}, a, x, ret[15:8], ret[7:0]};
            run(10, hv);
        end else begin
            for (k = 0; k < 10 && (op == 8'h8F ? cpu_wait : osc_stop) !== 1'b1; k++) tick(1);
            if (k == 10) stuck("halt entry");
            i = 1'b0;
            regs();
            tick(3);
            chk_byte("halt flag", 8'h01, {7'h00, cpu_wait | osc_stop});
            st = '{{3'h7, h, i, n, z, c}, a, x, ret[15:8], ret[7:0]};
            @(posedge clk) irq_pin_n <= 1'b0;
            #1;
            for (k = 0; k < 40 && mem_addr !== hv; k++) tick(1);
            if (k == 40) stuck("wake");
            irq_pin_n <= 1'b1;
            ipc = hv;
            chk_byte("halt flag", 8'h00, {7'h00, cpu_wait | osc_stop});
        end
        si = i;
        s = s - 8'h05;
        i = 1'b1;
        regs();
        for (k = 0; k < 5; k++) chk_byte("stack", st[k], u_mem_model.mem[{8'h00, s + 8'(k + 1)}]);
        put(hv, 8'h80);
        s = s + 8'h05;
        i = si;
        run(9, ret);
        regs();
    endtask

    initial begin
        logic [3:0] los [3] = '{4'h9, 4'hB, 4'h4};
        logic [7:0] bops [4] = '{8'h24, 8'h25, 8'h27, 8'h28};
        int k, j, m;
        resetn = 1'b0;
        ce = 1'b1;
        irq_pin_n = 1'b1;
        void'($urandom(32'hE0292875));
        {a, x, s, h, i, n, z, c} = {8'h00, 8'h00, 8'hFF, 5'h08};
        ipc = 16'h1000;
        #1;
        put(16'hFFFA, 8'h0E);
        put(16'hFFFB, 8'h00);
        put(16'hFFFC, 8'h0F);
        put(16'hFFFD, 8'h00);
        put(16'hFFFE, 8'h10);
        put(16'hFFFF, 8'h00);
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        #1;
        for (k = 0; k < 20 && mem_addr !== ipc; k++) tick(1);
        if (k == 20) stuck("reset fetch");
        for (k = 0; k < 4; k++) begin
            ctl($urandom_range(1) ? 8'h99 : 8'h98);
            for (j = 0; j < 3; j++) begin
                for (m = 0; m < 6; m++) begin
                    alu(los[j], 4'(m), 8'($urandom));
                    ctl(8'h97);
                end
            end
        end
        for (k = 0; k < 20; k++) begin
            sh(4'(3 + k % 5), (k < 10) ? 4'h8 : 4'h7, 8'($urandom));
        end
        for (k = 0; k < 32; k++) begin
            bits(k % 8, k[3], k[4], 16'($urandom));
        end
        for (k = 0; k < 16; k++) begin
            alu(4'hB, 4'h0, k[3] ? 8'h00 - a : 8'($urandom));
            ctl(k[0] ? 8'h99 : 8'h98);
            br(bops[k % 4], (k < 4) ? 8'h7F : (k < 8) ? 8'h80 : 8'($urandom));
        end
        ctl(8'h9F);
        ctl(8'h9D);
        ctl(8'h9C);
        put(ipc, 8'h9D);
        @(posedge clk) ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        run(1, ipc + 16'h0001);
        regs();
        trap(8'h83);
        trap(8'h8F);
        trap(8'h8E);
        test_done;
    end
endmodule // tb

bind cpu_bit_control_alu_decode cpu_bit_control_alu_decode_monitor u_monitor (
    .clk(clk), .resetn(resetn), .ce(ce), .irq_pin_n(irq_pin_n), .mem_addr(mem_addr),
    .mem_we(mem_we), .osc_stop(osc_stop), .cpu_wait(cpu_wait), .acc(acc), .pc(pc),
    .ccr(ccr));
